// *** ume_pkg.sv ***
package ume_pkg;
  // register indices; odd indices exist, so each register takes one aligned word
  localparam logic [11:0] MSR0_IDX       = 12'h0C6;
  localparam logic [11:0] MSR1_IDX       = 12'h0D6;
  localparam logic [11:0] IIR0_IDX       = 12'h0C2;
  localparam logic [11:0] IIR1_IDX       = 12'h0D2;
  localparam logic [11:0] MCTL0_IDX      = 12'h0C4;
  localparam logic [11:0] MCTL1_IDX      = 12'h0D4;
  localparam logic [11:0] IRCTL_IDX      = 12'h0BF;
  // apb byte addresses are four times the index
  localparam logic [11:0] MSR0_ADDR      = {MSR0_IDX[9:0], 2'h0};
  localparam logic [11:0] MSR1_ADDR      = {MSR1_IDX[9:0], 2'h0};
  localparam logic [11:0] IIR0_ADDR      = {IIR0_IDX[9:0], 2'h0};
  localparam logic [11:0] IIR1_ADDR      = {IIR1_IDX[9:0], 2'h0};
  localparam logic [11:0] MCTL0_ADDR     = {MCTL0_IDX[9:0], 2'h0};
  localparam logic [11:0] MCTL1_ADDR     = {MCTL1_IDX[9:0], 2'h0};
  localparam logic [11:0] IRCTL_ADDR     = {IRCTL_IDX[9:0], 2'h0};
  localparam logic [11:0] SRC_ADDR       = 12'h0E0;
  // modem control field positions
  localparam int          MCTL_DTR_BIT   = 0;
  localparam int          MCTL_RTS_BIT   = 1;
  localparam int          MCTL_OUTA_BIT  = 2;
  localparam int          MCTL_OUTB_BIT  = 3;
  localparam int          MCTL_LOOP_BIT  = 4;
  // infrared control fields
  localparam int          IRC_EN_BIT     = 0;
  localparam int          IRC_DIV_LSB    = 4;
  // interrupt status codes, ranked
  localparam logic [2:0]  CODE_LINE      = 3'h3;
  localparam logic [2:0]  CODE_RXRDY     = 3'h2;
  localparam logic [2:0]  CODE_TIMEOUT   = 3'h6;
  localparam logic [2:0]  CODE_TXDONE    = 3'h5;
  localparam logic [2:0]  CODE_NONE      = 3'h0;
  // reset values
  localparam logic [7:0]  MCTL_RST       = 8'h00;
  localparam logic [7:0]  IRCTL_RST      = 8'h00;
  localparam logic [7:0]  MSR_RST        = 8'h00;
  // infrared timing
  localparam logic [1:0]  DIV_LOW_BITS   = 2'h3;
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          MIN_PULSE_NS   = 1410;
  localparam int          MIN_PULSE_CYC  = (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0]  MAX_TICKS      = 8'h0F;
  localparam logic [7:0]  MIN_TICKS      = 8'h01;

  // one port's modem pins as they arrive, before synchronising
  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } ume_modem_t;

  // interrupt sources of one port
  typedef struct packed {
    logic line;
    logic rxrdy;
    logic timeout;
    logic txdone;
  } ume_irq_src_t;
endpackage

// *** ume_ir_endec.sv ***
`timescale 1ns/100ps
`default_nettype none
// infrared pulse encoder and decoder for port 0
module ume_ir_endec
  import ume_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_enable,
  input  wire logic [3:0] i_div_factor,
  input  wire logic       i_bit_tick,
  input  wire logic       i_txd,
  input  wire logic       i_ir_rx_sync,
  output logic            o_ir_tx,
  output logic            o_rxd
);
  logic [5:0] div_cnt_ff;
  logic       div_tick;
  logic [7:0] pulse_cnt_ff;
  logic       rx_prev_ff;
  logic       tx_pulse_ff;
  logic [7:0] tx_len_ff;
  logic       rxd_ff;
  logic       tx_busy;

  // six bit divider, low two bits fixed at ones; zero factor stops it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_ff <= 6'h00;
    end else if (i_div_factor == 4'h0) begin
      div_cnt_ff <= 6'h00;
    end else if (div_cnt_ff == {i_div_factor, DIV_LOW_BITS}) begin
      div_cnt_ff <= 6'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
    end
  end
  assign div_tick = (i_div_factor != 4'h0) && (div_cnt_ff == {i_div_factor, DIV_LOW_BITS});

  // encoder: one short pulse per zero bit, none per one bit
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_pulse_ff <= 1'b0;
      tx_len_ff   <= 8'h00;
    end else if (i_enable && i_bit_tick && !i_txd) begin
      tx_pulse_ff <= 1'b1;
      tx_len_ff   <= 8'(MIN_PULSE_CYC);
    end else if (tx_len_ff > 8'h01) begin
      tx_len_ff <= tx_len_ff - 8'h01;
    end else begin
      tx_pulse_ff <= 1'b0;
      tx_len_ff   <= 8'h00;
    end
  end
  assign o_ir_tx = tx_pulse_ff;
  // the uart line idles high between frames; low means a frame is going out
  assign tx_busy = tx_pulse_ff || !i_txd;

  // decoder: width of high pulses counted in divider ticks
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_prev_ff   <= 1'b0;
      pulse_cnt_ff <= 8'h00;
      rxd_ff       <= 1'b1;
    end else begin
      rx_prev_ff <= i_ir_rx_sync;
      if (!i_enable || tx_busy) begin
        pulse_cnt_ff <= 8'h00;
        rxd_ff       <= 1'b1;
      end else if (i_ir_rx_sync) begin
        if (div_tick && pulse_cnt_ff != 8'hFF) begin
          pulse_cnt_ff <= pulse_cnt_ff + 8'h01;
        end
      end else begin
        // on falling edge: an in-range pulse becomes a zero bit
        if (rx_prev_ff && pulse_cnt_ff >= MIN_TICKS && pulse_cnt_ff <= MAX_TICKS) begin
          rxd_ff <= 1'b0;
        end else if (i_bit_tick) begin
          rxd_ff <= 1'b1;
        end
        pulse_cnt_ff <= 8'h00;
      end
    end
  end
  assign o_rxd = rxd_ff;

  // a pulse is never sent while receive is decoding a zero
  ir_half_duplex_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    tx_pulse_ff |-> rxd_ff) else $error("ir receive active during transmit");
  ir_div_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_div_factor == 4'h0) |-> !div_tick) else $error("divider ticks with zero factor");
  ir_zero_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_enable && i_bit_tick && !i_txd) |=> tx_pulse_ff [*4]) else $error("zero bit pulse too short");
endmodule
`default_nettype wire

// *** ume_top.sv ***
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - interrupt codes ranked line, rx, timeout, txdone
// - status high nibble shows inverted modem pins
// - loop-back mirrors modem control bits instead
// - carrier change sets bit three
// - ring falling edge alone sets bit two
// - ready and clear changes set bits one, zero
// - status read clears change bits
// - endec encodes transmit, decodes receive
// - infrared stays half duplex
// - bit rate from port baud generator
// - accept pulses within standard width limits
// - received pulse width timed by six-bit divider
// - divider upper four programmable, lower ones
// - zero factor disables divider
// - only highest pending code reported
// - pending bit low while any source active
module ume_top
  import ume_pkg::*;
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic         i_psel,
  input  wire logic         i_penable,
  input  wire logic         i_pwrite,
  input  wire logic [11:0]  i_paddr,
  input  wire logic [31:0]  i_pwdata,
  output logic              o_pready,
  output logic              o_pslverr,
  output logic [31:0]       o_prdata,
  input  wire ume_modem_t   i_modem0,
  input  wire ume_modem_t   i_modem1,
  output logic [3:0]        o_modem_ctl0,
  output logic [3:0]        o_modem_ctl1,
  input  wire ume_irq_src_t i_irq_src0,
  input  wire ume_irq_src_t i_irq_src1,
  input  wire logic         i_port0_enabled,
  input  wire logic         i_baud_bit_tick,
  input  wire logic         i_uart0_txd,
  output logic              o_uart0_rxd,
  output logic              o_txd_pin,
  input  wire logic         i_rxd_pin,
  output logic              o_infrared_tx_out,
  input  wire logic         i_infrared_rx_in
);
  logic [7:0]  mctl_ff [2];
  logic [7:0]  infrared_control_ff;
  logic [3:0]  delta_ff [2];
  logic [3:0]  pin_s1_ff [2];
  logic [3:0]  pin_s2_ff [2];
  logic [3:0]  pin_prev_ff [2];
  logic [1:0]  rx_s_ff;
  logic [1:0]  irx_s_ff;
  logic [31:0] prdata_ff;
  logic        wr_en;
  logic        rd_en;
  logic        endec_on;
  logic        endec_rxd;
  logic [7:0]  msr_val [2];
  logic [7:0]  iir_val [2];
  logic        mapped;

  // ranked interrupt encoder, bit0 low while anything is pending
  function automatic logic [7:0] iir_encode(input ume_irq_src_t s);
    logic [2:0] code;
    code = CODE_NONE;
    if (s.line) begin
      code = CODE_LINE;
    end else if (s.rxrdy) begin
      code = CODE_RXRDY;
    end else if (s.timeout) begin
      code = CODE_TIMEOUT;
    end else if (s.txdone) begin
      code = CODE_TXDONE;
    end
    return {4'h0, code, ~(|s)};
  endfunction

  // address match used by both decode and read mux
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign o_pready = 1'b1; // zero wait states keeps the read-clear single-shot
  assign mapped = hit(i_paddr, MSR0_ADDR) || hit(i_paddr, MSR1_ADDR) || hit(i_paddr, IIR0_ADDR) ||
                  hit(i_paddr, IIR1_ADDR) || hit(i_paddr, MCTL0_ADDR) || hit(i_paddr, MCTL1_ADDR) ||
                  hit(i_paddr, IRCTL_ADDR);
  assign o_pslverr = i_psel && i_penable && !mapped;

  // modem pins cross in through two flops each
  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          pin_s1_ff[p]   <= 4'hF;
          pin_s2_ff[p]   <= 4'hF;
          pin_prev_ff[p] <= 4'hF;
        end else begin
          pin_s1_ff[p]   <= (p == 0) ? i_modem0 : i_modem1;
          pin_s2_ff[p]   <= pin_s1_ff[p];
          pin_prev_ff[p] <= pin_s2_ff[p];
        end
      end

      // status value: live levels or loop-back mirror over change flags
      always_comb begin
        if (mctl_ff[p][MCTL_LOOP_BIT]) begin
          msr_val[p] = {mctl_ff[p][MCTL_OUTB_BIT], mctl_ff[p][MCTL_OUTA_BIT],
                        mctl_ff[p][MCTL_DTR_BIT], mctl_ff[p][MCTL_RTS_BIT], delta_ff[p]};
        end else begin
          msr_val[p] = {~pin_s2_ff[p], delta_ff[p]};
        end
      end

      logic [3:0] ev;
      logic       rd_hit;
      // pin events seen between the compare flop and the second sync flop
      assign ev = {pin_s2_ff[p][3] ^ pin_prev_ff[p][3],
                   pin_prev_ff[p][2] & ~pin_s2_ff[p][2], // pin low-going edge
                   pin_s2_ff[p][1:0] ^ pin_prev_ff[p][1:0]};
      assign rd_hit = rd_en && hit(i_paddr, (p == 0) ? MSR0_ADDR : MSR1_ADDR);

      // change flags; a new edge in the read cycle survives the clear
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          delta_ff[p] <= MSR_RST[3:0];
        end else begin
          delta_ff[p] <= (rd_hit ? 4'h0 : delta_ff[p]) | ev;
        end
      end

      // modem control register, software writable
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          mctl_ff[p] <= MCTL_RST;
        end else if (wr_en && hit(i_paddr, (p == 0) ? MCTL0_ADDR : MCTL1_ADDR)) begin
          mctl_ff[p] <= i_pwdata[7:0];
        end
      end

      assign iir_val[p] = iir_encode((p == 0) ? i_irq_src0 : i_irq_src1);

      // ring falls (pin low-going) must show in flags one cycle later
      ring_edge_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (pin_prev_ff[p][2] && !pin_s2_ff[p][2]) |=> delta_ff[p][2]) else $error("ring edge lost");
      ring_rise_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!delta_ff[p][2] && !(pin_prev_ff[p][2] && !pin_s2_ff[p][2])) |=> !delta_ff[p][2])
        else $error("ring flag set without falling edge");
      carrier_change_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (pin_s2_ff[p][3] != pin_prev_ff[p][3]) |=> delta_ff[p][3]) else $error("carrier change lost");
      ready_cts_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $changed(pin_prev_ff[p][1:0]) |->
        ((delta_ff[p][1:0] & (pin_prev_ff[p][1:0] ^ $past(pin_prev_ff[p][1:0]))) ==
         (pin_prev_ff[p][1:0] ^ $past(pin_prev_ff[p][1:0]))))
        else $error("ready or cts change flag wrong");
      read_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (rd_en && hit(i_paddr, (p == 0) ? MSR0_ADDR : MSR1_ADDR) && pin_s2_ff[p] == pin_prev_ff[p])
        |=> delta_ff[p] == 4'h0) else $error("status read did not clear flags");
      loop_mirror_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        mctl_ff[p][MCTL_LOOP_BIT] |-> msr_val[p][7:4] == {mctl_ff[p][3:2], mctl_ff[p][0], mctl_ff[p][1]})
        else $error("loop-back mirror wrong");
      normal_pins_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !mctl_ff[p][MCTL_LOOP_BIT] |-> msr_val[p][7:4] == ~pin_s2_ff[p]) else $error("status not inverted pins");
    end
  endgenerate

  assign o_modem_ctl0 = mctl_ff[0][3:0];
  assign o_modem_ctl1 = mctl_ff[1][3:0];

  // infrared control: enable bit and divider factor
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      infrared_control_ff <= IRCTL_RST;
    end else if (wr_en && hit(i_paddr, IRCTL_ADDR)) begin
      infrared_control_ff <= i_pwdata[7:0];
    end
  end
  // endec only runs with the port itself enabled
  assign endec_on = infrared_control_ff[IRC_EN_BIT] && i_port0_enabled;

  // read data registered; msr reads are what clear the flags
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      prdata_ff <= 32'h0000_0000;
      if (hit(i_paddr, MSR0_ADDR)) prdata_ff[7:0] <= msr_val[0];
      if (hit(i_paddr, MSR1_ADDR)) prdata_ff[7:0] <= msr_val[1];
      if (hit(i_paddr, IIR0_ADDR)) prdata_ff[7:0] <= iir_val[0];
      if (hit(i_paddr, IIR1_ADDR)) prdata_ff[7:0] <= iir_val[1];
      if (hit(i_paddr, MCTL0_ADDR)) prdata_ff[7:0] <= mctl_ff[0];
      if (hit(i_paddr, MCTL1_ADDR)) prdata_ff[7:0] <= mctl_ff[1];
      if (hit(i_paddr, IRCTL_ADDR)) prdata_ff[7:0] <= infrared_control_ff;
    end
  end
  assign o_prdata = prdata_ff;

  // receive pins synchronised before the mux and decoder
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_s_ff  <= 2'h3;
      irx_s_ff <= 2'h0;
    end else begin
      rx_s_ff  <= {rx_s_ff[0], i_rxd_pin};
      irx_s_ff <= {irx_s_ff[0], i_infrared_rx_in};
    end
  end

  ume_ir_endec u_endec (
    .i_clk_sys    (i_clk_sys),
    .i_rst        (i_rst),
    .i_enable     (endec_on),
    .i_div_factor (infrared_control_ff[IRC_DIV_LSB +: 4]),
    .i_bit_tick   (i_baud_bit_tick),
    .i_txd        (i_uart0_txd),
    .i_ir_rx_sync (irx_s_ff[1]),
    .o_ir_tx      (o_infrared_tx_out),
    .o_rxd        (endec_rxd)
  );

  // pin paths swap over while the endec is on
  assign o_uart0_rxd = endec_on ? endec_rxd : rx_s_ff[1];
  assign o_txd_pin   = endec_on ? 1'b1 : i_uart0_txd;

  irq_rank_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_irq_src0.line && i_irq_src0.rxrdy) |-> iir_val[0][3:1] == CODE_LINE) else $error("lower code shown");
  irq_pending_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    iir_val[0][0] == !(|i_irq_src0)) else $error("pending bit wrong");
  irq_timeout_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_irq_src1 == 4'b0011) |-> iir_val[1][3:1] == CODE_TIMEOUT) else $error("timeout rank wrong");
  endec_swap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    endec_on |-> o_txd_pin && o_uart0_rxd == endec_rxd) else $error("plain pins not replaced");
endmodule
`default_nettype wire

// *** ume_far_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// modem lines of both ports and an infrared transceiver on the far side
module ume_far_model
  import ume_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_ir_tx,
  output var  ume_modem_t o_modem0,
  output var  ume_modem_t o_modem1,
  output logic            o_ir_rx
);
  // modem pins idle inactive (high), transceiver output idles dark
  initial begin
    o_modem0 = 4'hF;
    o_modem1 = 4'hF;
    o_ir_rx  = 1'b0;
  end

  // pins move just after an edge; the design treats them as async anyway
  task automatic set_modem(input int port, input logic [3:0] v);
    @(posedge i_clk_sys);
    if (port == 0) o_modem0 <= v;
    else o_modem1 <= v;
  endtask

  // a real transceiver sees its own light, so it never answers mid-send
  task automatic send_pulse(input int cyc);
    int n;
    n = 0;
    while (i_ir_tx === 1'b1 && n < 100) begin
      @(posedge i_clk_sys);
      n++;
    end
    @(posedge i_clk_sys);
    o_ir_rx <= 1'b1;
    repeat (cyc) @(posedge i_clk_sys);
    o_ir_rx <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** uart_modem_status_ir_endec_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module uart_modem_status_ir_endec_tb_top;
  import ume_pkg::*;
  logic         clk, rst, psel, penable, pwrite, port0_en, tick, txd, rxd_pin;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, rd;
  logic         err;
  logic         pready, pslverr, uart0_rxd, txd_pin, ir_tx, ir_rx;
  logic [31:0]  prdata;
  logic [3:0]   ctl0, ctl1;
  ume_modem_t   modem0, modem1;
  ume_irq_src_t irq0, irq1;
  int           failures, total_checks, cnt;
  // source patterns and the code each one must report
  logic [15:0]  srcs  = 16'hF731;
  logic [11:0]  codes = {CODE_LINE, CODE_RXRDY, CODE_TIMEOUT, CODE_TXDONE};

  `define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

  ume_top u_ume_top (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .i_modem0(modem0), .i_modem1(modem1),
    .o_modem_ctl0(ctl0), .o_modem_ctl1(ctl1), .i_irq_src0(irq0), .i_irq_src1(irq1),
    .i_port0_enabled(port0_en), .i_baud_bit_tick(tick), .i_uart0_txd(txd),
    .o_uart0_rxd(uart0_rxd), .o_txd_pin(txd_pin), .i_rxd_pin(rxd_pin),
    .o_infrared_tx_out(ir_tx), .i_infrared_rx_in(ir_rx));

  ume_far_model u_ume_far_model (.i_clk_sys(clk), .i_ir_tx(ir_tx), .o_modem0(modem0),
    .o_modem1(modem1), .o_ir_rx(ir_rx));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one apb transfer; data is taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      final_report();
    end
  endtask

  task automatic pulse_tick;
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
  endtask

  task automatic t_reset_unmapped;
    apb(0, MCTL0_ADDR, 0); `CHK("mctl0 reset", MCTL_RST, rd[7:0])
    apb(0, IRCTL_ADDR, 0); `CHK("irctl reset", IRCTL_RST, rd[7:0])
    apb(0, 12'h0A0, 0); `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
  endtask

  task automatic t_modem;
    apb(0, MSR0_ADDR, 0);
    apb(0, MSR1_ADDR, 0);
    u_ume_far_model.set_modem(0, 4'b0010);
    repeat (5) @(posedge clk);
    apb(0, MSR0_ADDR, 0); `CHK("msr0 edges", 8'hDD, rd[7:0])
    apb(0, MSR0_ADDR, 0); `CHK("msr0 cleared", 8'hD0, rd[7:0])
    // ring released (rising) must not flag; set-ready change must
    u_ume_far_model.set_modem(0, 4'b0100);
    repeat (5) @(posedge clk);
    apb(0, MSR0_ADDR, 0); `CHK("msr0 ring rise", 8'hB2, rd[7:0])
    u_ume_far_model.set_modem(1, 4'b1110);
    repeat (5) @(posedge clk);
    apb(0, MSR1_ADDR, 0); `CHK("msr1 cts", 8'h11, rd[7:0])
  endtask

  task automatic t_loop;
    apb(1, MCTL0_ADDR, 32'h0000_001A);
    @(posedge clk);
    `CHK("modem ctl0", 4'hA, ctl0)
    apb(0, MSR0_ADDR, 0); `CHK("msr0 loop", 4'h9, rd[7:4])
    apb(1, MCTL0_ADDR, 32'h0000_0000);
  endtask

  task automatic t_irq;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) irq0 <= ume_irq_src_t'(srcs[15-4*i -: 4]);
      repeat (2) @(posedge clk);
      apb(0, IIR0_ADDR, 0); `CHK("iir0 rank", {codes[11-3*i -: 3], 1'b0}, rd[3:0])
    end
    @(posedge clk) irq0 <= '0;
    repeat (2) @(posedge clk);
    apb(0, IIR0_ADDR, 0); `CHK("iir0 idle", 1'b1, rd[0])
    @(posedge clk) irq1 <= ume_irq_src_t'(4'h5);
    repeat (2) @(posedge clk);
    apb(0, IIR1_ADDR, 0); `CHK("iir1 rank", {CODE_RXRDY, 1'b0}, rd[3:0])
    @(posedge clk) irq1 <= ume_irq_src_t'(4'h3);
    repeat (2) @(posedge clk);
    apb(0, IIR1_ADDR, 0); `CHK("iir1 timeout", {CODE_TIMEOUT, 1'b0}, rd[3:0])
  endtask

  task automatic count_tx;
    cnt = 0;
    repeat (40) begin
      @(posedge clk);
      if (ir_tx === 1'b1) cnt++;
    end
  endtask

  task automatic t_ir_tx;
    // factor 2 suits a 10 MHz clock
    apb(1, IRCTL_ADDR, 32'h0000_0021);
    `CHK("txd pin idle", 1'b1, txd_pin)
    @(posedge clk) txd <= 1'b0;
    pulse_tick();
    count_tx(); `CHK("zero bit pulse", 15, cnt)
    @(posedge clk) txd <= 1'b1;
    pulse_tick();
    count_tx(); `CHK("one bit dark", 0, cnt)
    apb(1, IRCTL_ADDR, 32'h0000_0000);
    @(posedge clk) txd <= 1'b0; rxd_pin <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("plain txd", 1'b0, txd_pin)
    `CHK("plain rxd", 1'b0, uart0_rxd)
    @(posedge clk) txd <= 1'b1; rxd_pin <= 1'b1;
  endtask

  task automatic t_ir_rx;
    apb(1, IRCTL_ADDR, 32'h0000_0021);
    u_ume_far_model.send_pulse(24);
    repeat (4) @(posedge clk);
    `CHK("rx valid pulse", 1'b0, uart0_rxd)
    pulse_tick();
    repeat (3) @(posedge clk);
    `CHK("rx after tick", 1'b1, uart0_rxd)
    // far too wide for the tick window: must be dropped
    u_ume_far_model.send_pulse(220);
    repeat (4) @(posedge clk);
    `CHK("rx long pulse", 1'b1, uart0_rxd)
    apb(1, IRCTL_ADDR, 32'h0000_0001);
    u_ume_far_model.send_pulse(24);
    repeat (4) @(posedge clk);
    `CHK("rx divider off", 1'b1, uart0_rxd)
  endtask

  initial begin
    failures = 0; total_checks = 0; rst = 1'b1;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    irq0 = '0; irq1 = '0; tick = 1'b0; txd = 1'b1; rxd_pin = 1'b1;
    port0_en = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_unmapped();
    t_modem();
    t_loop();
    t_irq();
    t_ir_tx();
    t_ir_rx();
    final_report();
  end
endmodule
`default_nettype wire
